/* testbench/pfm_asserts.sv */
// assertion checker for the port function mux top ports
`timescale 1ns/1ps
module pfm_asserts
  import pfm_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [7:0]      p1_pin_out,
  input wire logic [7:0]      p1_pin_oe,
  input wire logic [5:0]      p2_pin_out,
  input wire logic            p1_irq,
  input wire pfm_periph_out_t periph_out,
  input wire pfm_periph_in_t  periph_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  a_ext_clk_low: assert property (periph_in.external_clock_in |-> !p1_pin_out[0])
    else $error("clock input pin not low");
  a_cap0_route: assert property (periph_in.capture_ch0_input_a |->
    p1_pin_out[1] == periph_out.compare_output_zero) else $error("bit 1 route");
  a_cap1_route: assert property (periph_in.capture_ch1_input_a |->
    p1_pin_out[2] == periph_out.compare_output_one) else $error("bit 2 route");
  a_cap2_route: assert property (periph_in.capture_ch2_input_a |->
    p1_pin_out[3] == periph_out.compare_output_two) else $error("bit 3 route");
  a_alt_clk_low: assert property (periph_in.alternate_clock_in |-> !p2_pin_out[1])
    else $error("alternate clock pin not low");
  a_cmp_route: assert property (periph_in.capture_ch0_input_b |->
    p2_pin_out[2] == periph_out.comparator_result) else $error("comparator route");
  a_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    p1_pin_oe == 8'h00 && !p1_irq) else $error("reset state wrong");
endmodule : pfm_asserts
bind pfm_port_function_mux pfm_asserts chk (.*);

/* testbench/pfm_periph_model.sv */
// far-side model: package pins and timer-side peripheral signals
`timescale 1ns/1ps
module pfm_periph_model
  import pfm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] ext1,
  input  wire logic [5:0] ext2,
  input  wire logic [7:0] p1_pin_out,
  input  wire logic [7:0] p1_pin_oe,
  input  wire logic [5:0] p2_pin_out,
  input  wire logic [5:0] p2_pin_oe,
  output logic      [7:0] p1_pin_in,
  output logic      [5:0] p2_pin_in,
  output pfm_periph_out_t periph_out
);
  logic [5:0] cnt;
  // ******************************
  // pin levels and timer outputs
  // ******************************
  // a driven pin shows the device level, otherwise the outside driver
  assign p1_pin_in = (p1_pin_oe & p1_pin_out) | (~p1_pin_oe & ext1);
  assign p2_pin_in = (p2_pin_oe & p2_pin_out) | (~p2_pin_oe & ext2);
  // free count so every mux leg sees both levels over a run
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt <= 6'h00;
    else
      cnt <= cnt + 6'h01;
  end
  assign periph_out = pfm_periph_out_t'(cnt);
endmodule : pfm_periph_model

/* testbench/testbench.sv */
// self-checking bench for the port function mux
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module testbench;
  import pfm_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d, q; logic [1:0] r;} pfm_row_t;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic p1_irq, p2_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [7:0] s_axi_awaddr, s_axi_araddr, p1_pin_in, p1_pin_out, p1_pin_oe, ext1;
  logic [5:0] p2_pin_in, p2_pin_out, p2_pin_oe, ext2, po;
  pfm_periph_out_t periph_out;
  pfm_periph_in_t periph_in;
  int error_cnt, cmp_count;
  logic [7:0] pa [3] = '{8'hff, 8'haa, 8'h00};
  logic [5:0] pb [3] = '{6'h3f, 6'h15, 6'h00};
  pfm_row_t rows [6] = '{'{PFM_P1_OUT, 32'ha5, 32'ha5, PFM_OKAY},
    '{PFM_P2_DIR, 32'hffffff3c, 32'h3c, PFM_OKAY}, '{PFM_P1_IES, 32'h5a, 32'h5a, PFM_OKAY},
    '{PFM_P2_SEL, 32'h11, 32'h11, PFM_OKAY}, '{PFM_P1_IN, 32'hff, 32'h00, PFM_OKAY},
    '{8'h40, 32'h11, 32'h00, PFM_SLVERR}};
  pfm_port_function_mux uut (.*);
  pfm_periph_model far (.*);
  // ******************************
  // bus and timing helpers
  // ******************************
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // ready is sampled mid-cycle so the taking edge never races the comb ready
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ah, wh, tb;
    ah = 0;
    wh = 0;
    tb = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ah && wh))
    begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      ah = ah | ta;
      wh = wh | tw;
    end
    s_axi_bready <= 1'b1;
    while (!tb)
    begin
      @(negedge clk);
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
    end
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic t;
    t = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!t)
    begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    t = 0;
    while (!t)
    begin
      @(negedge clk);
      t = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
    end
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext1, ext2} = '0;
    s_axi_wstrb = 4'hf;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    `CHK(p1_pin_oe, 8'h00)
    `CHK(p1_irq, 1'b0)
    foreach (rows[i])
    begin
      axw(rows[i].a, rows[i].d);
      `CHK(rs, rows[i].r)
      axr(rows[i].a);
      `CHK({rd, rs}, {rows[i].q, rows[i].r})
    end
    axw(PFM_P1_SEL, 32'hff);
    axw(PFM_P2_SEL, 32'h3f);
    axw(PFM_P1_DIR, 32'hff);
    axw(PFM_P2_DIR, 32'h3f);
    repeat (40)
    begin
      wt(1);
      po = periph_out;
      `CHK(p1_pin_out[3:0], {po[3], po[4], po[5], 1'b0})
      `CHK(p1_pin_out[7:4], {po[3], po[4], po[5], po[2]})
      `CHK(p2_pin_out[2:0], {po[0], 1'b0, po[1]})
      `CHK(p2_pin_out[5:3], {1'b0, po[3], po[4]})
      `CHK({p1_pin_oe, p2_pin_oe}, 14'h3fff)
    end
    axw(PFM_P1_DIR, 32'h00);
    axw(PFM_P2_DIR, 32'h00);
    wt(1);
    `CHK({p1_pin_oe, p2_pin_oe}, 14'h0000)
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      ext1 <= pa[k];
      ext2 <= pb[k];
      wt(8);
      `CHK(periph_in[5:4], {pa[k][0], pb[k][1]})
      `CHK(periph_in[3:0], {pa[k][1], pa[k][2], pa[k][3], pb[k][2]})
    end
    axw(PFM_P1_SEL, 32'h00);
    axw(PFM_P2_SEL, 32'h00);
    axw(PFM_P1_DIR, 32'hff);
    axw(PFM_P1_OUT, 32'h5a);
    wt(1);
    `CHK(p1_pin_out, 8'h5a)
    `CHK(periph_in, 6'h00)
    axw(PFM_P1_DIR, 32'h00);
    @(posedge clk);
    ext1 <= 8'hc3;
    wt(8);
    axr(PFM_P1_IN);
    `CHK(rd, 32'hc3)
    @(posedge clk);
    ext1 <= 8'h00;
    wt(8);
    axw(PFM_P1_IES, 32'h02);
    axw(PFM_P1_IE, 32'h03);
    axw(PFM_P1_IFG, 32'h00);
    @(posedge clk);
    ext1 <= 8'h03;
    wt(8);
    `CHK(p1_irq, 1'b1)
    axr(PFM_P1_IFG);
    `CHK(rd, 32'h01)
    @(posedge clk);
    ext1 <= 8'h00;
    wt(8);
    axr(PFM_P1_IFG);
    `CHK(rd, 32'h03)
    axw(PFM_P1_IE, 32'h00);
    wt(1);
    `CHK(p1_irq, 1'b0)
    axw(PFM_P2_IE, 32'hc0);
    axw(PFM_P2_IFG, 32'h40);
    wt(1);
    `CHK(p2_irq, 1'b1)
    axr(PFM_P2_IFG);
    `CHK(rd, 32'h40)
    axr(PFM_P2_IN);
    `CHK(rd[7:6], 2'b00)
    axw(PFM_P2_IFG, 32'h00);
    wt(1);
    `CHK(p2_irq, 1'b0)
    // second reset mid-run, with a live interrupt and driven pins
    axw(PFM_P1_IE, 32'h01);
    axw(PFM_P1_IFG, 32'h01);
    axw(PFM_P1_DIR, 32'hff);
    wt(1);
    `CHK(p1_irq, 1'b1)
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    `CHK({p1_pin_oe, p1_irq}, 9'h000)
    axr(PFM_P1_DIR);
    `CHK({rd, rs}, {32'h00000000, PFM_OKAY})
    wrap_up();
  end
endmodule : testbench

/* verilog/pfm_pkg.sv */
// package for the port function mux: register map, field layouts, constants
// Notes on behaviour
// [R1] port 1 bit 0 selected: output low, pin feeds timer external clock input.
// [R2] port 1 bits 1-3 selected: compare outputs 0-2 out, pins feed capture inputs A.
// [R3] port 1 bit 4 selected: sub-main clock out, pin input unused.
// [R4] port 1 bits 5-7 selected: compare outputs 0-2 out, pin inputs unused.
// [R5] port 2 bit 0 selected: auxiliary clock out, pin input unused.
// [R6] port 2 bit 1 selected: output low, pin feeds timer alternate clock input.
// [R7] port 2 bit 2 selected: comparator result out, pin feeds capture ch0 input B.
// [R8] port 2 bits 3-4 selected: compare outputs 1 and 2 out, pins unused.
// [R9] port 2 bit 5 selected: output low, pin input unused.
// [R10] every pin's driver enable comes only from its direction bit.
// [R11] port 2 bits 6-7 unbonded: output low, flags change only by software.
// [R12] unselected: pin driven from output bit; input bit shows synchronised pin level.
// [R13] flag sets on chosen edge (clear rising, set falling); irq when flag and enable.
package pfm_pkg;

  // ******************************
  // register map (byte addresses)
  // ******************************
  localparam logic [7:0] PFM_P1_IN   = 8'h00;
  localparam logic [7:0] PFM_P1_OUT  = 8'h04;
  localparam logic [7:0] PFM_P1_DIR  = 8'h08;
  localparam logic [7:0] PFM_P1_IFG  = 8'h0c;
  localparam logic [7:0] PFM_P1_IES  = 8'h10;
  localparam logic [7:0] PFM_P1_IE   = 8'h14;
  localparam logic [7:0] PFM_P1_SEL  = 8'h18;
  localparam logic [7:0] PFM_P2_IN   = 8'h20;
  localparam logic [7:0] PFM_P2_OUT  = 8'h24;
  localparam logic [7:0] PFM_P2_DIR  = 8'h28;
  localparam logic [7:0] PFM_P2_IFG  = 8'h2c;
  localparam logic [7:0] PFM_P2_IES  = 8'h30;
  localparam logic [7:0] PFM_P2_IE   = 8'h34;
  localparam logic [7:0] PFM_P2_SEL  = 8'h38;

  localparam int         PFM_ADDR_W  = 8;
  localparam logic [7:0] PFM_RST8    = 8'h00;
  localparam logic [1:0] PFM_OKAY    = 2'b00;
  localparam logic [1:0] PFM_SLVERR  = 2'b10;
  // bits of port 2 that have pins; 6 and 7 are unbonded
  localparam logic [7:0] PFM_P2_PINS = 8'h3f;

  // ******************************
  // carriers
  // ******************************
  typedef struct packed {
    logic [7:0] output_value;
    logic [7:0] direction;
    logic [7:0] irq_flag;
    logic [7:0] edge_select;
    logic [7:0] irq_enable;
    logic [7:0] function_select;
  } pfm_port_regs_t;

  typedef struct packed {
    logic compare_output_zero;
    logic compare_output_one;
    logic compare_output_two;
    logic sub_main_system_clock;
    logic auxiliary_clock;
    logic comparator_result;
  } pfm_periph_out_t;

  typedef struct packed {
    logic external_clock_in;
    logic alternate_clock_in;
    logic capture_ch0_input_a;
    logic capture_ch1_input_a;
    logic capture_ch2_input_a;
    logic capture_ch0_input_b;
  } pfm_periph_in_t;

endpackage : pfm_pkg

/* verilog/pfm_port_function_mux.sv */
// port function mux: two 8-bit ports, peripheral routing, edge interrupts, AXI4-Lite slave
`timescale 1ns/1ps
module pfm_port_function_mux
  import pfm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  // axi4-lite slave
  input  wire logic [PFM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [PFM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // pins
  input  wire logic [7:0]            p1_pin_in,
  output logic [7:0]                 p1_pin_out,
  output logic [7:0]                 p1_pin_oe,
  input  wire logic [5:0]            p2_pin_in,
  output logic [5:0]                 p2_pin_out,
  output logic [5:0]                 p2_pin_oe,
  // peripherals
  input  wire pfm_periph_out_t       periph_out,
  output pfm_periph_in_t             periph_in,
  output logic                       p1_irq,
  output logic                       p2_irq
);

  // ******************************
  // registers and pin synchronisers
  // ******************************
  pfm_port_regs_t p1;
  pfm_port_regs_t p2;
  logic [7:0]     p1_s1, p1_s2, p1_s3, p1_in;
  logic [5:0]     p2_s1, p2_s2, p2_s3, p2_in6;
  logic [7:0]     p2_in;
  logic [7:0]     p1_prev, p2_prev;
  logic [7:0]     p1_edge, p2_edge;

  // three stages; the level moves only when stages two and three agree
  // a one-cycle pin pulse never reaches the input register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      p1_s1 <= PFM_RST8;
      p1_s2 <= PFM_RST8;
      p1_s3 <= PFM_RST8;
      p1_in <= PFM_RST8;
      p2_s1 <= 6'h00;
      p2_s2 <= 6'h00;
      p2_s3 <= 6'h00;
      p2_in6 <= 6'h00;
    end
    else
    begin
      p1_s1 <= p1_pin_in;
      p1_s2 <= p1_s1;
      p1_s3 <= p1_s2;
      p1_in <= (p1_s2 & p1_s3) | (p1_in & (p1_s2 | p1_s3)); // see [R12]
      p2_s1 <= p2_pin_in;
      p2_s2 <= p2_s1;
      p2_s3 <= p2_s2;
      p2_in6 <= (p2_s2 & p2_s3) | (p2_in6 & (p2_s2 | p2_s3)); // see [R12]
    end
  end

  // unbonded bits read as zero
  assign p2_in = {2'b00, p2_in6};

  // ******************************
  // edge detection
  // ******************************
  // prev resets to the same level as the filtered input, so no false edge follows reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      p1_prev <= PFM_RST8;
      p2_prev <= PFM_RST8;
    end
    else
    begin
      p1_prev <= p1_in;
      p2_prev <= p2_in;
    end
  end

  function automatic logic [7:0] edge_hit(input logic [7:0] now, input logic [7:0] was,
                                          input logic [7:0] fall);
    edge_hit = (~fall & now & ~was) | (fall & ~now & was); // see [R13]
  endfunction : edge_hit

  assign p1_edge = edge_hit(p1_in, p1_prev, p1.edge_select);
  // only bonded bits can see pin edges
  assign p2_edge = edge_hit(p2_in, p2_prev, p2.edge_select) & PFM_P2_PINS; // see [R11]

  // ******************************
  // axi4-lite write path
  // ******************************
  logic                  aw_held, w_held;
  logic [PFM_ADDR_W-1:0] aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane;
  logic                  wr_fire;
  logic                  wr_hit;

  // readies stay low while a response waits, so only one write is ever in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  // address and data are latched apart, so either may come first
  assign wr_fire       = aw_held && w_held;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
    end
  end

  // only byte lane 0 carries register bits; the upper lanes are ignored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      w_held <= 1'b0;
      w_byte <= PFM_RST8;
      w_lane <= 1'b0;
    end
    else
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // writes to the input registers answer okay and change nothing
  always_comb
  begin
    unique case (aw_addr)
      PFM_P1_IN, PFM_P1_OUT, PFM_P1_DIR, PFM_P1_IFG, PFM_P1_IES, PFM_P1_IE, PFM_P1_SEL,
      PFM_P2_IN, PFM_P2_OUT, PFM_P2_DIR, PFM_P2_IFG, PFM_P2_IES, PFM_P2_IE, PFM_P2_SEL:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PFM_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? PFM_OKAY : PFM_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  function automatic logic wr_to(input logic [PFM_ADDR_W-1:0] a, input logic [7:0] off,
                                 input logic go, input logic lane);
    wr_to = go && lane && (a == off);
  endfunction : wr_to

  // ******************************
  // port registers; a pin edge beats a software write in the same cycle
  // ******************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      p1 <= '0;
    end
    else
    begin
      if (wr_to(aw_addr, PFM_P1_OUT, wr_fire, w_lane)) p1.output_value <= w_byte;
      if (wr_to(aw_addr, PFM_P1_DIR, wr_fire, w_lane)) p1.direction <= w_byte;
      if (wr_to(aw_addr, PFM_P1_IES, wr_fire, w_lane)) p1.edge_select <= w_byte;
      if (wr_to(aw_addr, PFM_P1_IE,  wr_fire, w_lane)) p1.irq_enable <= w_byte;
      if (wr_to(aw_addr, PFM_P1_SEL, wr_fire, w_lane)) p1.function_select <= w_byte;
      if (wr_to(aw_addr, PFM_P1_IFG, wr_fire, w_lane))
        p1.irq_flag <= w_byte | p1_edge; // see [R13]
      else
        p1.irq_flag <= p1.irq_flag | p1_edge; // see [R13]
    end
  end

  // bits 6 and 7 of port 2 see no pin edge, so only software moves their flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      p2 <= '0;
    end
    else
    begin
      if (wr_to(aw_addr, PFM_P2_OUT, wr_fire, w_lane)) p2.output_value <= w_byte;
      if (wr_to(aw_addr, PFM_P2_DIR, wr_fire, w_lane)) p2.direction <= w_byte;
      if (wr_to(aw_addr, PFM_P2_IES, wr_fire, w_lane)) p2.edge_select <= w_byte;
      if (wr_to(aw_addr, PFM_P2_IE,  wr_fire, w_lane)) p2.irq_enable <= w_byte;
      if (wr_to(aw_addr, PFM_P2_SEL, wr_fire, w_lane)) p2.function_select <= w_byte;
      if (wr_to(aw_addr, PFM_P2_IFG, wr_fire, w_lane))
        p2.irq_flag <= w_byte | p2_edge; // see [R11]
      else
        p2.irq_flag <= p2.irq_flag | p2_edge; // see [R13]
    end
  end

  // flag register is written directly, so software can both raise and clear a flag
  assign p1_irq = |(p1.irq_flag & p1.irq_enable); // see [R13]
  assign p2_irq = |(p2.irq_flag & p2.irq_enable); // see [R13]

  // ******************************
  // axi4-lite read path
  // ******************************
  logic [7:0] rd_byte;
  logic       rd_hit;

  // one read in flight: a new address waits until the data is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      PFM_P1_IN:  rd_byte = p1_in; // see [R12]
      PFM_P1_OUT: rd_byte = p1.output_value;
      PFM_P1_DIR: rd_byte = p1.direction;
      PFM_P1_IFG: rd_byte = p1.irq_flag;
      PFM_P1_IES: rd_byte = p1.edge_select;
      PFM_P1_IE:  rd_byte = p1.irq_enable;
      PFM_P1_SEL: rd_byte = p1.function_select;
      PFM_P2_IN:  rd_byte = p2_in;
      PFM_P2_OUT: rd_byte = p2.output_value;
      PFM_P2_DIR: rd_byte = p2.direction;
      PFM_P2_IFG: rd_byte = p2.irq_flag;
      PFM_P2_IES: rd_byte = p2.edge_select;
      PFM_P2_IE:  rd_byte = p2.irq_enable;
      PFM_P2_SEL: rd_byte = p2.function_select;
      default:
      begin
        rd_byte = PFM_RST8;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= PFM_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_hit ? PFM_OKAY : PFM_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ******************************
  // pin output multiplexing
  // ******************************
  logic [7:0] p1_func, p2_func, p2_drive;

  always_comb
  begin
    p1_func[0] = 1'b0;                                  // see [R1]
    p1_func[1] = periph_out.compare_output_zero;        // see [R2]
    p1_func[2] = periph_out.compare_output_one;         // see [R2]
    p1_func[3] = periph_out.compare_output_two;         // see [R2]
    p1_func[4] = periph_out.sub_main_system_clock;      // see [R3]
    p1_func[5] = periph_out.compare_output_zero;        // see [R4]
    p1_func[6] = periph_out.compare_output_one;         // see [R4]
    p1_func[7] = periph_out.compare_output_two;         // see [R4]
    p2_func[0] = periph_out.auxiliary_clock;            // see [R5]
    p2_func[1] = 1'b0;                                  // see [R6]
    p2_func[2] = periph_out.comparator_result;          // see [R7]
    p2_func[3] = periph_out.compare_output_one;         // see [R8]
    p2_func[4] = periph_out.compare_output_two;         // see [R8]
    p2_func[5] = 1'b0;                                  // see [R9]
    p2_func[6] = 1'b0;                                  // see [R11]
    p2_func[7] = 1'b0;                                  // see [R11]
  end

  // peripheral outputs pass through combinationally so clocks are not delayed a cycle
  assign p1_pin_out = (p1.function_select & p1_func) |
                      (~p1.function_select & p1.output_value); // see [R12]
  assign p2_drive   = (p2.function_select & p2_func) |
                      (~p2.function_select & p2.output_value); // see [R12]
  // bits 6 and 7 stop here: they have no pad to drive
  assign p2_pin_out = p2_drive[5:0]; // see [R11]
  // a selected peripheral never turns a pin around; direction alone enables the driver
  assign p1_pin_oe  = p1.direction; // see [R10]
  assign p2_pin_oe  = p2.direction[5:0]; // see [R10]

  // ******************************
  // pin inputs to peripherals; gated low when the function is not selected
  // ******************************
  always_comb
  begin
    periph_in.external_clock_in   = p1.function_select[0] & p1_in[0]; // see [R1]
    periph_in.capture_ch0_input_a = p1.function_select[1] & p1_in[1]; // see [R2]
    periph_in.capture_ch1_input_a = p1.function_select[2] & p1_in[2]; // see [R2]
    periph_in.capture_ch2_input_a = p1.function_select[3] & p1_in[3]; // see [R2]
    periph_in.alternate_clock_in  = p2.function_select[1] & p2_in[1]; // see [R6]
    periph_in.capture_ch0_input_b = p2.function_select[2] & p2_in[2]; // see [R7]
  end

endmodule : pfm_port_function_mux
